/* File: link_align_pkg.sv */
// Shared constants, register map and symbol codes for the serial link framer
package link_align_pkg;
    // Register map at printed offsets
    localparam logic [7:0] ADDR_OUTPUT_FORMAT = 8'h14;
    localparam logic [7:0] ADDR_DRIVE_SWING = 8'h15;
    localparam logic [7:0] ADDR_PLL_CONTROL = 8'h21;
    localparam logic [7:0] ADDR_LINK_CONTROL = 8'h33;
    // Values after reset
    localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h00;
    localparam logic [7:0] RST_DRIVE_SWING = 8'h00;
    localparam logic [7:0] RST_PLL_CONTROL = 8'h08;
    localparam logic [7:0] RST_LINK_CONTROL = 8'h00;
    // Field positions
    localparam int FMT_INVERT_BIT = 2;
    localparam int DRIVE_BOOST_BIT = 0;
    localparam int PLL_FULL_RATE_BIT = 3;
    localparam int LINK_SCRAMBLE_BIT = 0;
    localparam int LINK_TAIL_OVR_BIT = 3;
    // Output coding selections in output format bits [1:0]
    localparam logic [1:0] FMT_OFFSET_BINARY = 2'h0;
    localparam logic [1:0] FMT_TWOS_COMPLEMENT = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    // Line symbol codes (octet value with control flag)
    localparam logic [7:0] K28_5_CODE = 8'hbc;
    localparam logic [7:0] K28_7_CODE = 8'hfc;
    localparam logic [7:0] D28_7_CODE = 8'hfc;
    // Sync pin must be low this many cycles to enter sync mode
    localparam logic [1:0] SYNC_LOW_CYCLES = 2'h2;
    // Scrambler state after reset; any value works, the scrambler self-synchronises
    localparam logic [14:0] SCR_SEED = 15'h7fff;
endpackage

/* File: link_receiver_model.sv */
// Behavioural far-end receiver: comma lock, sync pin, octet position and K28.7 restore
`timescale 1ns/10ps
module link_receiver_model
    import link_align_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sym_data,
    input wire logic sym_is_k,
    input wire logic scramble_on,
    input wire logic hold_sync,
    output logic sync_n,
    output logic [15:0] rx_word,
    output logic rx_valid,
    output logic rx_comma
);
    logic [7:0] comma_count;
    logic [7:0] bad_symbol_count;
    logic [7:0] good_run_count;
    logic octet_position;
    logic prev_position;
    logic [7:0] msb_hold;
    logic [7:0] prev_lsb;
    logic [14:0] dscr_reg;
    logic [22:0] dscr_work;
    logic is_fill;
    logic sym_valid;
    logic sym_invalid;
    logic lost_lock;
    logic [7:0] restored;
    logic [7:0] plain;

    // Mirror of the line scrambler fed with received bits, so it self-synchronises
    function automatic logic [22:0] descramble(input logic [14:0] st, input logic [7:0] s);
        logic [14:0] r;
        logic [7:0] o;
        r = st;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = s[i] ^ r[13] ^ r[14];
            r = {r[13:0], s[i]};
        end
        return {r, o};
    endfunction

    ////////////////////////////////////////////////////////////////
    // Octet-level stand-in for disparity checks: only the two commas are legal controls
    assign sym_valid = !sym_is_k || sym_data == K28_5_CODE || sym_data == K28_7_CODE;
    assign sym_invalid = !sym_valid;
    assign lost_lock = bad_symbol_count >= 8'h03;
    // Restore before the descrambler sees the octet
    assign is_fill = sym_is_k && (sym_data == K28_7_CODE);
    assign restored = is_fill ? (scramble_on ? D28_7_CODE : prev_lsb) : sym_data;
    assign dscr_work = descramble(dscr_reg, restored);
    assign plain = scramble_on ? dscr_work[7:0] : restored;

    // Lock, check counters, position and frame assembly; sync released after four commas
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            comma_count <= 8'h00;
            bad_symbol_count <= 8'h00;
            good_run_count <= 8'h00;
            octet_position <= 1'b0;
            prev_position <= 1'b1;
            msb_hold <= 8'h00;
            prev_lsb <= 8'h00;
            dscr_reg <= 15'h0000;
            rx_word <= 16'h0000;
            rx_valid <= 1'b0;
            rx_comma <= 1'b0;
            sync_n <= 1'b0; // Reset counts as lost lock
        end else begin
            rx_valid <= 1'b0;
            sync_n <= !hold_sync && !lost_lock && (comma_count >= 8'h04);
            if (hold_sync || lost_lock) begin
                comma_count <= 8'h00;
            end else if (sym_is_k && sym_data == K28_5_CODE && comma_count != 8'hff) begin
                comma_count <= comma_count + 8'h01;
            end
            // Check-phase counters only run while the link is released
            if (!sync_n) begin
                bad_symbol_count <= 8'h00;
                good_run_count <= 8'h00;
            end else if (sym_invalid) begin
                bad_symbol_count <= bad_symbol_count + 8'h01;
                good_run_count <= 8'h00;
            end else if (good_run_count != 8'hff) begin
                good_run_count <= good_run_count + 8'h01;
            end
            if (sym_is_k && sym_data == K28_5_CODE) begin
                octet_position <= 1'b0; // First data octet is the MSB
            end else begin
                dscr_reg <= dscr_work[22:8];
                if (octet_position == 1'b0) begin
                    msb_hold <= plain;
                end else begin
                    rx_word <= {msb_hold, plain};
                    rx_valid <= 1'b1;
                    rx_comma <= is_fill;
                    prev_lsb <= restored;
                end
                octet_position <= !octet_position;
                if (is_fill) begin
                    prev_position <= octet_position;
                    if (octet_position == prev_position && sym_valid) begin
                        octet_position <= 1'b0; // Realign on matching comma
                    end
                end
            end
        end
    end
endmodule

/* File: link_scrambler.sv */
// Self-synchronising octet scrambler, polynomial 1 + x^14 + x^15
`timescale 1ns/10ps
module link_scrambler
    import link_align_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    octet_if.scrambler port
);
    typedef struct packed {
        logic [14:0] st;
    } scr_state_t;

    scr_state_t s_reg;
    scr_state_t s_next;
    logic [22:0] work;

    // Eight bits MSB first; each output bit feeds back into the shift register
    function automatic logic [22:0] scramble(input logic [14:0] st, input logic [7:0] d);
        logic [14:0] r;
        logic [7:0] o;
        r = st;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ r[13] ^ r[14];
            r = {r[13:0], o[i]};
        end
        return {r, o};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_next = s_reg;
        work = scramble(s_reg.st, port.data_in);
        if (port.step) begin
            s_next.st = work[22:8];
        end
    end

    assign port.data_out = work[7:0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '{st: SCR_SEED};
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_scr_state_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !port.step |=> $stable(s_reg.st))
        else $error("scrambler state moved without a step");
endmodule

/* File: octet_if.sv */
// Carrier between the framer and its scrambler
`timescale 1ns/10ps
interface octet_if;
    logic [7:0] data_in;
    logic step;
    logic [7:0] data_out;
    modport client (output data_in, output step, input data_out);
    modport scrambler (input data_in, input step, output data_out);
endinterface

/* File: serial_link_frame_alignment.sv */
// Transmit framer: sample coding, two-octet frames, sync mode and comma substitution
`timescale 1ns/10ps
module serial_link_frame_alignment
    import link_align_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [11:0] sample_data,
    input wire logic over_range,
    input wire logic programmable_pin_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic sample_req,
    output logic [7:0] sym_data,
    output logic sym_is_k,
    output logic tx_enable,
    output logic drive_boost,
    output logic pll_low_rate
);
    typedef struct packed {
        logic sync_s1;
        logic sync_s2;
        logic [1:0] low_cnt;
        logic sync_mode;
        logic phase;
        logic [7:0] lsb_pend;
        logic [7:0] prev_lsb;
        logic prev_ok;
        logic [7:0] fmt_ctrl;
        logic [7:0] drive_ctrl;
        logic [7:0] pll_ctrl;
        logic [7:0] link_ctrl;
        logic drive_boost;
        logic pll_low_rate;
        logic [7:0] rdata;
        logic [7:0] sym;
        logic sym_k;
        logic sample_req;
        logic tx_en;
    } frm_state_t;

    localparam frm_state_t FRM_RESET = '{
        sync_s1: 1'b0, sync_s2: 1'b0, low_cnt: 2'h0, sync_mode: 1'b1, phase: 1'b0,
        lsb_pend: 8'h00, prev_lsb: 8'h00, prev_ok: 1'b0,
        fmt_ctrl: RST_OUTPUT_FORMAT, drive_ctrl: RST_DRIVE_SWING,
        pll_ctrl: RST_PLL_CONTROL, link_ctrl: RST_LINK_CONTROL,
        drive_boost: RST_DRIVE_SWING[DRIVE_BOOST_BIT],
        pll_low_rate: !RST_PLL_CONTROL[PLL_FULL_RATE_BIT],
        rdata: 8'h00, sym: K28_5_CODE, sym_k: 1'b1, sample_req: 1'b0, tx_en: 1'b1};

    frm_state_t s_reg;
    frm_state_t s_next;
    logic [11:0] fmt_word;
    logic scr_on;
    octet_if scr_bus();

    // Offset binary in, selected coding out; invert applies last
    function automatic logic [11:0] code_sample(input logic [11:0] b, input logic [7:0] ctl);
        logic [11:0] c;
        unique case (ctl[1:0])
            FMT_TWOS_COMPLEMENT: c = {~b[11], b[10:0]};
            FMT_GRAY: c = b ^ {1'b0, b[11:1]};
            default: c = b; // Code 3 is unassigned; falls back to offset binary
        endcase
        return ctl[FMT_INVERT_BIT] ? ~c : c;
    endfunction

    assign fmt_word = code_sample(sample_data, s_reg.fmt_ctrl);
    assign scr_on = s_reg.link_ctrl[LINK_SCRAMBLE_BIT];

    link_scrambler u_scr (
        .clk_sys(clk_sys),
        .rst(rst),
        .port(scr_bus.scrambler)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state: register port, sync detection, octet sequencing
    always_comb begin
        s_next = s_reg;
        scr_bus.data_in = 8'h00;
        scr_bus.step = 1'b0;
        // Pin passes two flops before anything looks at it
        s_next.sync_s1 = programmable_pin_n;
        s_next.sync_s2 = s_reg.sync_s1;
        // Register writes and reads
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_OUTPUT_FORMAT: s_next.fmt_ctrl = reg_wdata;
                ADDR_DRIVE_SWING: begin
                    s_next.drive_ctrl = reg_wdata;
                    s_next.drive_boost = reg_wdata[DRIVE_BOOST_BIT];
                end
                ADDR_PLL_CONTROL: begin
                    s_next.pll_ctrl = reg_wdata;
                    s_next.pll_low_rate = !reg_wdata[PLL_FULL_RATE_BIT];
                end
                ADDR_LINK_CONTROL: s_next.link_ctrl = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_OUTPUT_FORMAT: s_next.rdata = s_reg.fmt_ctrl;
                ADDR_DRIVE_SWING: s_next.rdata = s_reg.drive_ctrl;
                ADDR_PLL_CONTROL: s_next.rdata = s_reg.pll_ctrl;
                ADDR_LINK_CONTROL: s_next.rdata = s_reg.link_ctrl;
                default: s_next.rdata = 8'h00; // Unmapped reads as zero
            endcase
        end
        // Count low cycles of the synchronised pin, saturating
        if (!s_reg.sync_s2) begin
            if (s_reg.low_cnt != SYNC_LOW_CYCLES) begin
                s_next.low_cnt = s_reg.low_cnt + 2'h1;
            end
        end else begin
            s_next.low_cnt = 2'h0;
        end
        // One octet per clock
        if (s_reg.sync_mode) begin
            s_next.sym = K28_5_CODE;
            s_next.sym_k = 1'b1;
            s_next.phase = 1'b0;
            s_next.prev_ok = 1'b0; // No valid previous LSB across a resync
            if (s_reg.sync_s2) begin
                s_next.sync_mode = 1'b0; // First real octet is the MSB one
            end
        end else if (!s_reg.phase) begin
            scr_bus.data_in = fmt_word[11:4];
            scr_bus.step = scr_on;
            s_next.sym = scr_on ? scr_bus.data_out : fmt_word[11:4];
            s_next.sym_k = 1'b0;
            s_next.lsb_pend = {fmt_word[3:0], s_reg.link_ctrl[LINK_TAIL_OVR_BIT] & over_range, 3'h0};
            s_next.phase = 1'b1;
        end else begin
            scr_bus.data_in = s_reg.lsb_pend;
            scr_bus.step = scr_on;
            if (scr_on) begin
                s_next.sym = scr_bus.data_out;
                s_next.sym_k = scr_bus.data_out == D28_7_CODE;
            end else begin
                // Compare with the previous frame's raw LSB octet, not what was sent
                s_next.sym_k = s_reg.prev_ok && s_reg.lsb_pend == s_reg.prev_lsb;
                s_next.sym = s_next.sym_k ? K28_7_CODE : s_reg.lsb_pend;
            end
            s_next.prev_lsb = s_reg.lsb_pend;
            s_next.prev_ok = 1'b1;
            s_next.phase = 1'b0;
        end
        // Entry wins over everything else in the octet sequence
        if (!s_reg.sync_s2 && s_reg.low_cnt == SYNC_LOW_CYCLES - 2'h1) begin
            s_next.sync_mode = 1'b1;
        end
        s_next.sample_req = !s_next.sync_mode && !s_next.phase;
        s_next.tx_en = 1'b1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= FRM_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign reg_rdata = s_reg.rdata;
    assign sample_req = s_reg.sample_req;
    assign sym_data = s_reg.sym;
    assign sym_is_k = s_reg.sym_k;
    assign tx_enable = s_reg.tx_en;
    assign drive_boost = s_reg.drive_boost;
    assign pll_low_rate = s_reg.pll_low_rate;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_sync_entry: assert property (!s_reg.sync_s2 [*2] |=> s_reg.sync_mode)
        else $error("sync pin low two cycles did not enter sync mode");
    a_sync_comma: assert property (s_reg.sync_mode |=> sym_is_k && sym_data == K28_5_CODE)
        else $error("sync mode did not send K28.5");
    a_tx_enabled: assert property (tx_enable)
        else $error("serial output not enabled");
    a_frame_order: assert property (!s_reg.sync_mode && !s_reg.phase && !s_next.sync_mode
        |=> s_reg.phase && !sym_is_k ##1 !s_reg.phase)
        else $error("frame not sent as MSB then LSB octet");
    a_msb_content: assert property (!s_reg.sync_mode && !s_reg.phase && !scr_on
        |=> sym_data == $past(fmt_word[11:4]))
        else $error("MSB octet does not carry sample bits 11..4");
    a_default_code: assert property (s_reg.fmt_ctrl == RST_OUTPUT_FORMAT
        |-> fmt_word == sample_data)
        else $error("default coding is not offset binary");
    a_repeat_comma: assert property (!s_reg.sync_mode && s_reg.phase && !scr_on
        |=> sym_is_k == $past(s_reg.prev_ok && s_reg.lsb_pend == s_reg.prev_lsb)
            && sym_data == (sym_is_k ? K28_7_CODE : $past(s_reg.lsb_pend)))
        else $error("repeated LSB octet substitution wrong");
    a_scr_comma: assert property (!s_reg.sync_mode && s_reg.phase && scr_on
        |=> sym_is_k == (sym_data == D28_7_CODE))
        else $error("scrambled D28.7 not sent as K28.7");
    a_pll_rate: assert property (reg_wr && reg_addr == ADDR_PLL_CONTROL
        |=> pll_low_rate == !$past(reg_wdata[PLL_FULL_RATE_BIT]))
        else $error("PLL low-rate selection wrong");
    a_drive_swing: assert property (reg_wr && reg_addr == ADDR_DRIVE_SWING
        |=> drive_boost == $past(reg_wdata[DRIVE_BOOST_BIT]))
        else $error("drive swing option not applied");

    c_sync_exit: cover property (s_reg.sync_mode ##1 !s_reg.sync_mode);
    c_plain_comma: cover property (!scr_on && sym_is_k && sym_data == K28_7_CODE);
    c_scr_comma: cover property (scr_on && sym_is_k && sym_data == K28_7_CODE);
    c_gray_mode: cover property (s_reg.fmt_ctrl[1:0] == FMT_GRAY && sample_req);
endmodule

/* File: tb.sv */
// Self-checking bench for the serial link framer
`timescale 1ns/10ps
module tb;
    import link_align_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [11:0] sample_data = 12'h000;
    logic over_range = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic scramble_on = 1'b0;
    logic hold_sync = 1'b0;
    logic [7:0] reg_rdata, sym_data, q;
    logic sample_req, sym_is_k, tx_enable, drive_boost, pll_low_rate, sync_n, rx_valid, rx_comma;
    logic [15:0] rx_word;
    int fail_count = 0;
    int cmp_count = 0;
    // Rows: format, sample, expected coded word
    logic [25:0] rows [8] = '{{2'h0, 12'h800, 12'h800}, {2'h0, 12'hfff, 12'hfff}, {2'h0, 12'h000, 12'h000},
        {2'h0, 12'habc, 12'habc}, {2'h1, 12'h800, 12'h000}, {2'h1, 12'h7ff, 12'hfff},
        {2'h2, 12'h800, 12'hc00}, {2'h2, 12'habc, 12'hfe2}};
    logic [7:0] reg_addrs [5] = '{ADDR_OUTPUT_FORMAT, ADDR_DRIVE_SWING, ADDR_PLL_CONTROL, ADDR_LINK_CONTROL, 8'h40};
    logic [7:0] reg_resets [5] = '{RST_OUTPUT_FORMAT, RST_DRIVE_SWING, RST_PLL_CONTROL, RST_LINK_CONTROL, 8'h00};

    ////////////////////////////////////////////////////////////////
    serial_link_frame_alignment dut (.clk_sys(clk_sys), .rst(rst), .sample_data(sample_data),
        .over_range(over_range), .programmable_pin_n(sync_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_req(sample_req),
        .sym_data(sym_data), .sym_is_k(sym_is_k), .tx_enable(tx_enable), .drive_boost(drive_boost),
        .pll_low_rate(pll_low_rate));
    link_receiver_model partner (.clk_sys(clk_sys), .rst(rst), .sym_data(sym_data), .sym_is_k(sym_is_k),
        .scramble_on(scramble_on), .hold_sync(hold_sync), .sync_n(sync_n), .rx_word(rx_word),
        .rx_valid(rx_valid), .rx_comma(rx_comma));

    // 100 MHz clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One register cycle, strobes raised and dropped on falling edges
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        @(negedge clk_sys);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        r = reg_rdata;
    endtask

    // Bounded wait for n restored frames at the partner
    task automatic wait_frames(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge clk_sys);
            while (rx_valid !== 1'b1 && k < 200) begin
                @(negedge clk_sys);
                k++;
            end
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog; the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        fail_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        check(sym_data, K28_5_CODE); // Sync mode during reset
        check(tx_enable, 1'b1);
        check(drive_boost, 1'b0);
        check(pll_low_rate, 1'b0);
        @(negedge clk_sys);
        rst = 1'b0;
        // Reset values, including an unmapped place
        for (int i = 0; i < 5; i++) begin
            reg_op(1'b0, reg_addrs[i], 8'h00, q);
            check(q, reg_resets[i]);
        end
        check(tx_enable, 1'b1);
        // Table of coding cases; held samples repeat so LSB is filled
        for (int i = 0; i < 8; i++) begin
            reg_op(1'b1, ADDR_OUTPUT_FORMAT, {6'h00, rows[i][25:24]}, q);
            sample_data = rows[i][23:12];
            wait_frames(3);
            check(rx_word, {rows[i][11:0], 4'h0});
            check(rx_comma, 1'b1);
        end
        // Tail bit carries over-range when enabled
        reg_op(1'b1, ADDR_OUTPUT_FORMAT, 8'h00, q);
        reg_op(1'b1, ADDR_LINK_CONTROL, 8'h08, q);
        over_range = 1'b1;
        sample_data = 12'h5a3;
        wait_frames(3);
        check(rx_word, 16'h5a38);
        reg_op(1'b0, ADDR_LINK_CONTROL, 8'h00, q);
        check(q, 8'h08);
        // Resync in mid-run, then data must come back MSB first
        hold_sync = 1'b1;
        repeat (10) @(negedge clk_sys);
        check({sym_is_k, sym_data}, {1'b1, K28_5_CODE});
        check(sample_req, 1'b0);
        hold_sync = 1'b0;
        wait_frames(3);
        check(rx_word, 16'h5a38);
        // Drive swing, low rate loop, unmapped write ignored
        reg_op(1'b1, ADDR_DRIVE_SWING, 8'h01, q);
        reg_op(1'b1, ADDR_PLL_CONTROL, 8'h00, q);
        reg_op(1'b1, 8'h40, 8'hff, q);
        reg_op(1'b0, 8'h40, 8'h00, q);
        check(q, 8'h00);
        check(drive_boost, 1'b1);
        check(pll_low_rate, 1'b1);
        reg_op(1'b1, ADDR_PLL_CONTROL, 8'h08, q);
        reg_op(1'b0, ADDR_PLL_CONTROL, 8'h00, q);
        check(q, 8'h08);
        check(pll_low_rate, 1'b0);
        // Scrambling on; partner descrambler needs two scrambled octets to fall in step
        reg_op(1'b1, ADDR_LINK_CONTROL, 8'h09, q);
        scramble_on = 1'b1;
        wait_frames(4);
        check(rx_word, 16'h5a38);
        check(partner.bad_symbol_count, 8'h00);
        check(partner.good_run_count != 8'h00, 1'b1);
        close_out();
    end
endmodule
